// *** scsi_target_model.sv ***
`timescale 1ns/1ns
module scsi_target_model (
  // Clock.
  input  wire logic       clk_i,
  // Bench control: answer delay and silence.
  input  wire logic [3:0] delay_i,
  input  wire logic       mute_i,
  // Disk bus.
  input  wire logic       arb_req_i,
  input  wire logic       sel_i,
  output logic            arb_won_o,
  output logic            sel_resp_o
);
  logic [1:0] phase;
  logic [3:0] cnt;

  initial begin
    phase = 2'h0;
    cnt = 4'h0;
    arb_won_o = 1'b0;
    sel_resp_o = 1'b0;
  end

  // The answer delay restarts with every phase change.
  always @(posedge clk_i) begin
    phase <= {sel_i, arb_req_i};
    if ({sel_i, arb_req_i} != phase) begin
      cnt <= 4'h0;
    end else if (cnt != 4'hF) begin
      cnt <= cnt + 4'h1;
    end
    arb_won_o <= arb_req_i && (cnt >= delay_i);
    sel_resp_o <= sel_i && !mute_i && (cnt >= delay_i);
  end
endmodule

// *** select_timer.sv ***
`timescale 1ns/1ns
`include "strap_consts.svh"

module select_timer #(
  parameter int SHORT_CYCLES = `SEL_SHORT_US * `CLK_MHZ,
  parameter int LONG_CYCLES  = `SEL_LONG_MS * 1000 * `CLK_MHZ
) (
  // Clock and reset.
  input  wire logic clk_i,
  input  wire logic rst_i,
  // Control and result.
  input  wire logic run_i,
  input  wire logic long_i,
  output logic      expired_o
);

  logic [24:0] count;
  logic [24:0] next_count;
  logic [24:0] limit;
  logic        next_expired;

  // The count restarts whenever the selection phase is left.
  always_comb begin
    limit        = long_i ? 25'(LONG_CYCLES - 1) : 25'(SHORT_CYCLES - 1);
    next_count   = 25'h0000000;
    next_expired = 1'b0;
    if (run_i) begin
      if (count >= limit) begin
        next_count   = count;
        next_expired = 1'b1;
      end else begin
        next_count = count + 25'h0000001;
      end
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      count     <= 25'h0000000;
      expired_o <= 1'b0;
    end else begin
      count     <= next_count;
      expired_o <= next_expired;
    end
  end

endmodule

// *** strap_consts.svh ***
`ifndef STRAP_CONSTS_SVH
`define STRAP_CONSTS_SVH

`define REG_CMD          8'h00
`define REG_STATUS       8'h04
`define REG_ADDR         8'h08
`define REG_HDR          8'h0C
`define REG_IRQ_STAT     8'h10
`define REG_IRQ_MASK     8'h14

`define OP_WSWR          3'h0
`define OP_READ          3'h1
`define OP_WRITE         3'h2
`define OP_SEEK          3'h3
`define OP_RDHDR         3'h4

`define CMD_GO_BIT       31
`define CMD_LOCK_LSB     8

`define EV_DONE          0
`define EV_TIMEOUT       1
`define EV_LOCK_ERR      2
`define EV_TEST_DONE     3

`define MASK_RESET       4'h0
`define ADDR_RESET       22'h000000
`define HDR_RESET        16'h0000

`define CLK_MHZ          100
`define SEL_SHORT_US     250
`define SEL_LONG_MS      250
`define SELF_TEST_CYCLES 8'h10
`define PU_CAPTURE       2'h2
`define PU_DONE          2'h3

`endif

// *** strap_option_control.sv ***
`timescale 1ns/1ns
`include "strap_consts.svh"
////////////////////////////////////////////////////////////////////////////////
////////////////////////////////////////////////////////////////////////////////
module strap_option_control #(
  parameter int SHORT_SEL_CYCLES = `SEL_SHORT_US * `CLK_MHZ,
  parameter int LONG_SEL_CYCLES  = `SEL_LONG_MS * 1000 * `CLK_MHZ
) (
  // Clock and reset.
  input  wire logic                  clk_i,
  input  wire logic                  rst_i,
  // Register bus.
  input  wire strap_pkg::wb_req_type wb_i,
  output logic [31:0]                wb_dat_o,
  output logic                       wb_ack_o,
  output logic                       irq_o,
  // Option straps, closed is high.
  input  wire logic                  hard_reset_strap_i,
  input  wire logic                  auto_seek_strap_i,
  input  wire logic                  powerup_write_protect_strap_i,
  input  wire logic                  long_select_timeout_strap_i,
  input  wire logic                  arbitration_disable_strap_i,
  input  wire logic                  wide_address_strap_i,
  // Disk bus.
  input  wire logic                  arb_won_i,
  input  wire logic                  sel_resp_i,
  output logic                       arb_req_o,
  output logic                       sel_o,
  // Formatter commands.
  output logic                       seek_strobe_o,
  output logic [15:0]                seek_target_o,
  output logic                       xfer_strobe_o,
  output logic                       xfer_write_o,
  output logic [1:0]                 xfer_drive_o,
  // Host address.
  output logic [21:0]                host_addr_o,
  output logic                       host_addr_hi_oe_o,
  // Status.
  output logic                       halted_o,
  output logic                       self_test_o,
  output logic [3:0]                 write_lock_o
);
  import strap_pkg::*;

  function automatic logic hit(input logic [7:0] adr, input logic [7:0] off);
    return adr[7:2] == off[7:2];
  endfunction

  function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] nw,
                                        input logic [3:0] sel);
    logic [31:0] res;
    res = old;
    for (int i = 0; i < 4; i++) begin
      if (sel[i]) begin
        res[i*8 +: 8] = nw[i*8 +: 8];
      end
    end
    return res;
  endfunction

  function automatic logic rw_op(input logic [2:0] op);
    return (op == `OP_READ) || (op == `OP_WRITE);
  endfunction

  function automatic logic bus_op(input logic [2:0] op);
    return rw_op(op) || (op == `OP_SEEK) || (op == `OP_RDHDR);
  endfunction

  ////////////////////////////////////////////////////////////////////////////////
  // Strap and pin synchronisers.
  logic [7:0] sync;
  logic       hard_sync;
  logic       auto_sync;
  logic       wp_sync;
  logic       long_sync;
  logic       arbdis_sync;
  logic       wide_sync;
  logic       won_sync;
  logic       resp_sync;

  strap_sync #(.W(8)) u_sync (
    .clk_i (clk_i),
    .d_i   ({hard_reset_strap_i, auto_seek_strap_i, powerup_write_protect_strap_i,
             long_select_timeout_strap_i, arbitration_disable_strap_i,
             wide_address_strap_i, arb_won_i, sel_resp_i}),
    .q_o   (sync)
  );

  assign {hard_sync, auto_sync, wp_sync, long_sync, arbdis_sync,
          wide_sync, won_sync, resp_sync} = sync;

  ////////////////////////////////////////////////////////////////////////////////
  // Power-up capture of the write-protect strap.
  logic [1:0] pu_cnt;
  logic [1:0] next_pu_cnt;
  logic       pu_done;
  logic       next_pu_done;
  logic       pu_wp;
  logic       next_pu_wp;
  logic       rst_all;

  always_comb begin
    next_pu_cnt  = pu_cnt;
    next_pu_done = pu_done;
    next_pu_wp   = pu_wp;
    if (!pu_done) begin
      next_pu_cnt = pu_cnt + 2'h1;
      if (pu_cnt == `PU_CAPTURE) begin
        next_pu_wp = wp_sync;
      end
      if (pu_cnt == `PU_DONE) begin
        next_pu_done = 1'b1;
      end
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      pu_cnt  <= 2'h0;
      pu_done <= 1'b0;
      pu_wp   <= 1'b0;
    end else begin
      pu_cnt  <= next_pu_cnt;
      pu_done <= next_pu_done;
      pu_wp   <= next_pu_wp;
    end
  end

  assign rst_all = rst_i || hard_sync || !pu_done;

  ////////////////////////////////////////////////////////////////////////////////
  // Bus decode.
  logic take;
  logic wr;
  logic rd;
  logic wr_go;

  assign take  = wb_i.cyc && wb_i.stb && !wb_ack_o;
  assign wr    = take && wb_i.we;
  assign rd    = take && !wb_i.we;
  assign wr_go = wr && hit(wb_i.adr, `REG_CMD) && wb_i.sel[3] && wb_i.dat[`CMD_GO_BIT];

  ////////////////////////////////////////////////////////////////////////////////
  // Command sequencer.
  seq_state_type state;
  seq_state_type next_state;
  cmd_type       cmd;
  cmd_type       next_cmd;
  cmd_type       new_cmd;
  logic [7:0]    test_cnt;
  logic [7:0]    next_test_cnt;
  logic [3:0]    next_locks;
  logic [3:0]    ev;
  logic          expired;

  select_timer #(
    .SHORT_CYCLES (SHORT_SEL_CYCLES),
    .LONG_CYCLES  (LONG_SEL_CYCLES)
  ) u_timer (
    .clk_i     (clk_i),
    .rst_i     (rst_all),
    .run_i     (state == S_SEL),
    .long_i    (long_sync),
    .expired_o (expired)
  );

  always_comb begin
    next_state    = state;
    next_cmd      = cmd;
    next_test_cnt = test_cnt;
    next_locks    = write_lock_o;
    ev            = 4'h0;
    new_cmd.op    = wb_i.dat[2:0];
    new_cmd.drive = wb_i.dat[4:3];
    unique case (state)
      S_HALT: begin
        next_state    = S_TEST;
        next_test_cnt = 8'h00;
      end
      S_TEST: begin
        next_test_cnt = test_cnt + 8'h01;
        if (test_cnt == `SELF_TEST_CYCLES - 8'h01) begin
          next_state          = S_IDLE;
          ev[`EV_TEST_DONE]   = 1'b1;
        end
      end
      S_IDLE: begin
        if (wr_go) begin
          next_cmd = new_cmd;
          if (new_cmd.op == `OP_WSWR) begin
            next_locks    = wb_i.dat[`CMD_LOCK_LSB +: 4];
            ev[`EV_DONE]  = 1'b1;
          end else if (new_cmd.op == `OP_WRITE && write_lock_o[new_cmd.drive]) begin
            ev[`EV_LOCK_ERR] = 1'b1;
          end else if (bus_op(new_cmd.op)) begin
            next_state = arbdis_sync ? S_SEL : S_ARB;
          end else begin
            ev[`EV_DONE] = 1'b1;
          end
        end
      end
      S_ARB: begin
        if (won_sync) begin
          next_state = S_SEL;
        end
      end
      S_SEL: begin
        if (resp_sync) begin
          if ((auto_sync && rw_op(cmd.op)) || cmd.op == `OP_SEEK) begin
            next_state = S_SEEK;
          end else if (rw_op(cmd.op)) begin
            next_state = S_XFER;
          end else begin
            next_state   = S_IDLE;
            ev[`EV_DONE] = 1'b1;
          end
        end else if (expired) begin
          next_state      = S_IDLE;
          ev[`EV_TIMEOUT] = 1'b1;
        end
      end
      S_SEEK: begin
        if (rw_op(cmd.op)) begin
          next_state = S_XFER;
        end else begin
          next_state   = S_IDLE;
          ev[`EV_DONE] = 1'b1;
        end
      end
      S_XFER: begin
        next_state   = S_IDLE;
        ev[`EV_DONE] = 1'b1;
      end
      default: begin
        next_state = S_HALT;
      end
    endcase
  end

  always_ff @(posedge clk_i) begin
    if (rst_all) begin
      state         <= S_HALT;
      cmd           <= '0;
      test_cnt      <= 8'h00;
      write_lock_o  <= {4{pu_wp}};
      halted_o      <= 1'b1;
      self_test_o   <= 1'b0;
      arb_req_o     <= 1'b0;
      sel_o         <= 1'b0;
      seek_strobe_o <= 1'b0;
      xfer_strobe_o <= 1'b0;
      xfer_write_o  <= 1'b0;
    end else begin
      state         <= next_state;
      cmd           <= next_cmd;
      test_cnt      <= next_test_cnt;
      write_lock_o  <= next_locks;
      halted_o      <= next_state == S_HALT;
      self_test_o   <= next_state == S_TEST;
      arb_req_o     <= next_state == S_ARB;
      sel_o         <= next_state == S_SEL;
      seek_strobe_o <= next_state == S_SEEK;
      xfer_strobe_o <= next_state == S_XFER;
      xfer_write_o  <= next_cmd.op == `OP_WRITE;
    end
  end

  assign xfer_drive_o = cmd.drive;

  ////////////////////////////////////////////////////////////////////////////////
  // Register file and interrupt.
  logic [21:0] addr;
  logic [21:0] next_addr;
  logic [15:0] next_hdr;
  logic [3:0]  stat;
  logic [3:0]  next_stat;
  logic [3:0]  mask;
  logic [3:0]  next_mask;
  logic [31:0] next_rdata;
  logic [31:0] status_word;

  assign status_word = {20'h00000, write_lock_o, 1'b0, wide_sync, arbdis_sync, long_sync,
                        pu_wp, auto_sync, self_test_o, state != S_IDLE};

  always_comb begin
    next_addr  = addr;
    next_hdr   = seek_target_o;
    next_mask  = mask;
    next_stat  = stat | ev;
    next_rdata = 32'h00000000;
    if (wr && hit(wb_i.adr, `REG_ADDR)) begin
      next_addr = 22'(merge({10'h000, addr}, wb_i.dat, wb_i.sel));
    end
    if (wr && hit(wb_i.adr, `REG_HDR)) begin
      next_hdr = 16'(merge({16'h0000, seek_target_o}, wb_i.dat, wb_i.sel));
    end
    if (wr && hit(wb_i.adr, `REG_IRQ_MASK)) begin
      next_mask = 4'(merge({28'h0000000, mask}, wb_i.dat, wb_i.sel));
    end
    if (rd) begin
      if (hit(wb_i.adr, `REG_CMD)) begin
        next_rdata = {27'h0000000, cmd.drive, cmd.op};
      end else if (hit(wb_i.adr, `REG_STATUS)) begin
        next_rdata = status_word;
      end else if (hit(wb_i.adr, `REG_ADDR)) begin
        next_rdata = {10'h000, addr};
      end else if (hit(wb_i.adr, `REG_HDR)) begin
        next_rdata = {16'h0000, seek_target_o};
      end else if (hit(wb_i.adr, `REG_IRQ_STAT)) begin
        next_rdata = {28'h0000000, stat};
        next_stat  = ev;
      end else if (hit(wb_i.adr, `REG_IRQ_MASK)) begin
        next_rdata = {28'h0000000, mask};
      end
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_all) begin
      addr              <= `ADDR_RESET;
      seek_target_o     <= `HDR_RESET;
      mask              <= `MASK_RESET;
      stat              <= 4'h0;
      wb_ack_o          <= 1'b0;
      wb_dat_o          <= 32'h00000000;
      irq_o             <= 1'b0;
      host_addr_o       <= 22'h000000;
      host_addr_hi_oe_o <= 1'b0;
    end else begin
      addr              <= next_addr;
      seek_target_o     <= next_hdr;
      mask              <= next_mask;
      stat              <= next_stat;
      wb_ack_o          <= take;
      wb_dat_o          <= next_rdata;
      irq_o             <= |(next_stat & next_mask);
      host_addr_o       <= wide_sync ? addr : {4'h0, addr[17:0]};
      host_addr_hi_oe_o <= wide_sync;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Checks.
  logic [24:0] sel_cycles;

  always_ff @(posedge clk_i) begin
    if (state != S_SEL) begin
      sel_cycles <= 25'h0000000;
    end else begin
      sel_cycles <= sel_cycles + 25'h0000001;
    end
  end

  a_reset_clears:
    assert property (@(posedge clk_i) rst_all |=> (stat == 4'h0 && !irq_o && !wb_ack_o))
      else $error("Reset left status or bus state set.");
  a_halt_held:
    assert property (@(posedge clk_i) disable iff (rst_i)
      hard_sync |=> (halted_o && !arb_req_o && !sel_o && !xfer_strobe_o))
      else $error("Sequencer ran during reset strap.");
  a_self_test_start:
    assert property (@(posedge clk_i) disable iff (rst_i) $fell(rst_all) |=> self_test_o)
      else $error("Self-test did not follow reset release.");
  a_auto_seek_order:
    assert property (@(posedge clk_i) disable iff (rst_all)
      (state == S_SEL && resp_sync && rw_op(cmd.op)) |=>
        (seek_strobe_o == $past(auto_sync)) ##[0:1] xfer_strobe_o)
      else $error("Auto-seek sequence wrong.");
  a_powerup_lock:
    assert property (@(posedge clk_i) disable iff (rst_i)
      $rose(pu_done) |-> write_lock_o == {4{pu_wp}})
      else $error("Power-up write lock not applied.");
  a_lock_command:
    assert property (@(posedge clk_i) disable iff (rst_all)
      (state == S_IDLE && wr_go && wb_i.dat[2:0] == `OP_WSWR) |=>
        write_lock_o == $past(wb_i.dat[11:8]))
      else $error("Write-lock command not applied.");
  a_sel_timeout:
    assert property (@(posedge clk_i) disable iff (rst_all)
      ev[`EV_TIMEOUT] |-> sel_cycles == (long_sync ? 25'(LONG_SEL_CYCLES)
                                                   : 25'(SHORT_SEL_CYCLES)))
      else $error("Selection time-out length wrong.");
  a_arb_skip:
    assert property (@(posedge clk_i) disable iff (rst_all)
      (state == S_IDLE && wr_go && bus_op(wb_i.dat[2:0]) &&
       !(wb_i.dat[2:0] == `OP_WRITE && write_lock_o[wb_i.dat[4:3]])) |=>
        (arb_req_o == !$past(arbdis_sync)) && (sel_o == $past(arbdis_sync)))
      else $error("Arbitration phase choice wrong.");
  a_wide_addr:
    assert property (@(posedge clk_i) disable iff (rst_all)
      !$past(rst_all) |-> host_addr_hi_oe_o == $past(wide_sync))
      else $error("Upper address enable does not follow strap.");
  a_narrow_addr:
    assert property (@(posedge clk_i) !host_addr_hi_oe_o |-> host_addr_o[21:18] == 4'h0)
      else $error("Upper address bits driven in narrow mode.");
  a_wp_frozen:
    assert property (@(posedge clk_i) disable iff (rst_i) pu_done |=> $stable(pu_wp))
      else $error("Write-protect strap resampled after power-up.");

endmodule

// *** strap_option_control_tb.sv ***
`timescale 1ns/1ns
`include "strap_consts.svh"
module strap_option_control_tb;
  import strap_pkg::*;
  logic        clk_i, rst_i, wb_ack_o, irq_o, hard, auto, wp, lng, arbd, wide;
  wb_req_type  wb_i;
  logic [31:0] wb_dat_o, q;
  logic        arb_won, sel_resp, arb_req, sel, seek_stb, xfer_stb, xfer_wr;
  logic        hi_oe, halted, self_test, mute, got_wr;
  logic [15:0] seek_tgt, got_tgt, h;
  logic [1:0]  xfer_drv, got_drv, drv;
  logic [21:0] host_addr, a;
  logic [3:0]  wlock, delay, lk;
  logic [2:0]  op;
  int          fail_count, checks, cyc_count, n_seek, n_xfer, n_arb, n_sel, seek_at, xfer_at;

  strap_option_control #(.SHORT_SEL_CYCLES(20), .LONG_SEL_CYCLES(60)) dut_u (
    .clk_i(clk_i), .rst_i(rst_i), .wb_i(wb_i), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o),
    .irq_o(irq_o), .hard_reset_strap_i(hard), .auto_seek_strap_i(auto),
    .powerup_write_protect_strap_i(wp), .long_select_timeout_strap_i(lng),
    .arbitration_disable_strap_i(arbd), .wide_address_strap_i(wide),
    .arb_won_i(arb_won), .sel_resp_i(sel_resp), .arb_req_o(arb_req), .sel_o(sel),
    .seek_strobe_o(seek_stb), .seek_target_o(seek_tgt), .xfer_strobe_o(xfer_stb),
    .xfer_write_o(xfer_wr), .xfer_drive_o(xfer_drv), .host_addr_o(host_addr),
    .host_addr_hi_oe_o(hi_oe), .halted_o(halted), .self_test_o(self_test),
    .write_lock_o(wlock));

  scsi_target_model tgt_u (.clk_i(clk_i), .delay_i(delay), .mute_i(mute),
    .arb_req_i(arb_req), .sel_i(sel), .arb_won_o(arb_won), .sel_resp_o(sel_resp));

  ////////////////////////////////////////////////////////////////////////////////
  initial begin
    clk_i = 1'b0;
    forever #5 clk_i = ~clk_i;
  end

  // Records strobes and phases on the disk side, and cuts a hang short.
  always @(posedge clk_i) begin
    cyc_count <= cyc_count + 1;
    if (seek_stb) begin
      n_seek <= n_seek + 1;
      got_tgt <= seek_tgt;
      seek_at <= cyc_count;
    end
    if (xfer_stb) begin
      n_xfer <= n_xfer + 1;
      got_wr <= xfer_wr;
      got_drv <= xfer_drv;
      xfer_at <= cyc_count;
    end
    if (arb_req) n_arb <= n_arb + 1;
    if (sel) n_sel <= n_sel + 1;
    if (cyc_count == 20000) begin
      fail_count++;
      end_of_test();
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  task automatic end_of_test;
    $display("checks %0d mismatches %0d", checks, fail_count);
    if (fail_count == 0 && checks > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask

  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    checks++;
    if (g !== e) begin
      fail_count++;
      $display("unexpected %s expected %h seen %h", nm, e, g);
    end
  endtask

  task automatic wb(input logic we, input logic [7:0] ad, input logic [31:0] d);
    int n;
    n = 0;
    wb_i <= '{cyc: 1'b1, stb: 1'b1, we: we, adr: ad, sel: 4'hF, dat: d};
    do begin
      @(posedge clk_i);
      n++;
    end while (wb_ack_o !== 1'b1 && n < 50);
    chk("wb_ack", 32'h1, 32'(n < 50));
    q = wb_dat_o;
    wb_i <= '0;
    @(posedge clk_i);
  endtask

  task automatic run(input logic [2:0] o, input logic [1:0] dr, input logic [3:0] l);
    int n;
    n_seek = 0;
    n_xfer = 0;
    n_arb = 0;
    n_sel = 0;
    wb(1'b1, `REG_CMD, 32'h8000_0000 | {20'h0, l, 3'h0, dr, o});
    n = 0;
    q = 32'h1;
    while (q[0] !== 1'b0 && n < 100) begin
      wb(1'b0, `REG_STATUS, 32'h0);
      n++;
    end
    chk("busy", 32'h0, 32'(q[0]));
  endtask

  task automatic wait_st(input logic v);
    int n;
    n = 0;
    while (self_test !== v && n < 40) begin
      @(posedge clk_i);
      n++;
    end
    chk("self_test", 32'(v), 32'(self_test));
  endtask

  ////////////////////////////////////////////////////////////////////////////////
  initial begin
    {rst_i, hard, auto, wp, lng, arbd, wide, mute} = 8'h90;
    wb_i = '0;
    delay = 4'h0;
    {fail_count, checks, cyc_count, n_seek, n_xfer, n_arb, n_sel, seek_at, xfer_at} = '0;
    q = $urandom(32'h2db9);
    repeat (10) @(posedge clk_i);
    chk("halted", 32'h1, 32'(halted));
    rst_i <= 1'b0;
    wait_st(1'b1);
    wait_st(1'b0);
    chk("wlock", 32'hF, 32'(wlock));
    wp <= 1'b0;
    repeat (6) @(posedge clk_i);
    chk("wlock_hold", 32'hF, 32'(wlock));
    wb(1'b0, `REG_IRQ_MASK, 32'h0);
    chk("mask_reset", 32'h0, q);
    $display("test powerup done");
    lk = 4'($urandom);
    run(`OP_WSWR, 2'h0, lk);
    chk("wlock", 32'(lk), 32'(wlock));
    wb(1'b0, `REG_STATUS, 32'h0);
    chk("status_lock", 32'(lk), 32'(q[11:8]));
    run(`OP_WSWR, 2'h0, 4'h1);
    wb(1'b0, `REG_IRQ_STAT, 32'h0);
    run(`OP_WRITE, 2'h0, 4'h0);
    chk("locked_xfer", 32'h0, 32'(n_xfer));
    wb(1'b0, `REG_IRQ_STAT, 32'h0);
    chk("lock_event", 32'h1, 32'(q[`EV_LOCK_ERR]));
    run(`OP_WSWR, 2'h0, 4'h0);
    $display("test locks done");
    for (int i = 0; i < 4; i++) begin
      auto <= i[0];
      arbd <= i[1];
      delay <= 4'($urandom % 4);
      h = 16'($urandom);
      wb(1'b1, `REG_HDR, {16'h0, h});
      op = ($urandom % 2) ? `OP_WRITE : `OP_READ;
      drv = 2'($urandom);
      run(op, drv, 4'h0);
      chk("seek_count", 32'(i[0]), 32'(n_seek));
      chk("xfer_count", 32'h1, 32'(n_xfer));
      chk("arbitration", 32'(!i[1]), 32'(n_arb != 0));
      chk("xfer_write", 32'(op == `OP_WRITE), 32'(got_wr));
      chk("xfer_drive", 32'(drv), 32'(got_drv));
      if (i[0]) chk("seek_target", 32'(h), 32'(got_tgt));
      if (i[0]) chk("seek_order", 32'(seek_at + 1), 32'(xfer_at));
    end
    run(`OP_SEEK, 2'h2, 4'h0);
    chk("seek_op", 32'h1, 32'(n_seek));
    chk("seek_op_xfer", 32'h0, 32'(n_xfer));
    chk("seek_op_target", 32'(h), 32'(got_tgt));
    run(`OP_RDHDR, 2'h2, 4'h0);
    chk("rdhdr_select", 32'h1, 32'(n_sel != 0));
    chk("rdhdr_strobes", 32'h0, 32'(n_seek + n_xfer));
    $display("test transfers done");
    {auto, arbd, mute} <= 3'b001;
    for (int l = 0; l < 2; l++) begin
      lng <= l[0];
      wb(1'b0, `REG_IRQ_STAT, 32'h0);
      run(`OP_READ, 2'h1, 4'h0);
      // Selection lasts the time-out plus the cycle in which it is left.
      chk("select_cycles", l[0] ? 32'd61 : 32'd21, 32'(n_sel));
      wb(1'b0, `REG_IRQ_STAT, 32'h0);
      chk("timeout_event", 32'h1, 32'(q[`EV_TIMEOUT]));
    end
    mute <= 1'b0;
    $display("test timeout done");
    for (int w = 0; w < 2; w++) begin
      wide <= w[0];
      a = 22'($urandom);
      wb(1'b1, `REG_ADDR, {10'h0, a});
      repeat (4) @(posedge clk_i);
      chk("host_addr", 32'(w[0] ? a : {4'h0, a[17:0]}), 32'(host_addr));
      chk("addr_enable", 32'(w[0]), 32'(hi_oe));
    end
    $display("test address done");
    wb(1'b0, `REG_IRQ_STAT, 32'h0);
    wb(1'b1, `REG_IRQ_MASK, 32'h1);
    run(3'h5, 2'h0, 4'h0);
    repeat (2) @(posedge clk_i);
    chk("irq_set", 32'h1, 32'(irq_o));
    wb(1'b0, `REG_IRQ_STAT, 32'h0);
    chk("done_event", 32'h1, 32'(q[`EV_DONE]));
    repeat (2) @(posedge clk_i);
    chk("irq_clear", 32'h0, 32'(irq_o));
    wb(1'b0, 8'h20, 32'h0);
    chk("unmapped", 32'h0, q);
    $display("test interrupt done");
    wb(1'b1, `REG_ADDR, 32'h0003_1234);
    hard <= 1'b1;
    repeat (6) @(posedge clk_i);
    chk("halted_hard", 32'h1, 32'(halted));
    chk("no_test_hard", 32'h0, 32'(self_test));
    hard <= 1'b0;
    wait_st(1'b1);
    wait_st(1'b0);
    wb(1'b0, `REG_ADDR, 32'h0);
    chk("addr_cleared", 32'h0, q);
    wb(1'b0, `REG_IRQ_MASK, 32'h0);
    chk("mask_cleared", 32'h0, q);
    chk("wlock_reload", 32'hF, 32'(wlock));
    $display("test hard reset done");
    end_of_test();
  end
endmodule

// *** strap_pkg.sv ***
package strap_pkg;

  typedef enum logic [2:0] {
    S_HALT,
    S_TEST,
    S_IDLE,
    S_ARB,
    S_SEL,
    S_SEEK,
    S_XFER
  } seq_state_type;

  typedef struct packed {
    logic        cyc;
    logic        stb;
    logic        we;
    logic [7:0]  adr;
    logic [3:0]  sel;
    logic [31:0] dat;
  } wb_req_type;

  typedef struct packed {
    logic [2:0] op;
    logic [1:0] drive;
  } cmd_type;

endpackage

// *** strap_sync.sv ***
`timescale 1ns/1ns

module strap_sync #(
  parameter int W = 8
) (
  // Clock.
  input  wire logic         clk_i,
  // Asynchronous levels and their synchronised copies.
  input  wire logic [W-1:0] d_i,
  output logic      [W-1:0] q_o
);

  logic [W-1:0] meta;

  // Two stages; the first is read by the second only.
  always_ff @(posedge clk_i) begin
    meta <= d_i;
    q_o  <= meta;
  end

endmodule
